// ==== rtl/alert_defines.svh ====
`ifndef ALERT_DEFINES_SVH
`define ALERT_DEFINES_SVH

// Two-wire byte values
`define GC_ADDR_BYTE 8'h00
`define GC_RESET_BYTE 8'h06
`define ARA_BYTE 8'h19

// Widths
`define TEMP_W 12
`define STAT_W 8
`define ADDR_W 7

// Status register field positions
`define STAT_OPEN_BIT 2
`define STAT_LOW_BIT 3
`define STAT_HIGH_BIT 4

// Power-on values
`define STAT_RESET 8'h00
`define TEMP_RESET 12'h000

// Bit counter marks
`define BIT_LAST 4'h7
`define BIT_DONE 4'h8

`endif

// ==== rtl/alert_pkg.sv ====
`include "alert_defines.svh"

package alert_pkg;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_GC = 8'h08,
    ST_GC_ACK = 8'h10,
    ST_ARA = 8'h20,
    ST_ARA_ACK = 8'h40,
    ST_SKIP = 8'h80
  } link_state_e;

  typedef struct packed {
    logic [`TEMP_W-1:0] local_t;
    logic [`TEMP_W-1:0] remote_t;
  } temp_pair_s;

  typedef struct packed {
    logic high;
    logic low;
  } limit_evt_s;

endpackage

// ==== rtl/result_hold.sv ====
`timescale 1ns/1ps
`include "alert_defines.svh"

module result_hold (
  input wire logic ref_clk,
  input wire logic clear,
  input wire logic we_local,
  input wire logic we_remote,
  input wire alert_pkg::temp_pair_s wdata,
  output alert_pkg::temp_pair_s rdata
);

  alert_pkg::temp_pair_s hold_q;

  // Each half is written alone so a faulty remote reading leaves the old value
  always_ff @(posedge ref_clk)
  begin
    if (clear)
    begin
      hold_q.local_t <= `TEMP_RESET;
      hold_q.remote_t <= `TEMP_RESET;
    end
    else
    begin
      if (we_local)
      begin
        hold_q.local_t <= wdata.local_t;
      end
      if (we_remote)
      begin
        hold_q.remote_t <= wdata.remote_t;
      end
    end
  end

  assign rdata = hold_q;

endmodule

// ==== rtl/smbus_alert_reset_fault_ctrl.sv ====
`timescale 1ns/1ps
`include "alert_defines.svh"

// Behaviour
// - Alert response handled only while alarm pin serves as alert output.
// - With alert active, acknowledge alert response and send own address.
// - Returned address LSB is 1 for high limit, 0 for low limit.
// - Arbitrate on address bits; winner releases alert when command completes.
// - Loser of address arbitration keeps its alert output asserted.
// - Shutdown bit high stops at once, abandoning any running conversion.
// - In shutdown conversions stop; serial interface, status and alarm outputs stay alive.
// - Shutdown bit low runs conversions back to back.
// - Diode fault during conversion keeps previous valid remote result.
// - Diode fault sets open-sensor flag at status bit 2.
// - Diode fault pulls alert output low when alert is enabled.
// - Supply not valid skips conversions and keeps the last result.
// - Acknowledge general call address 00h and take its second byte.
// - Second byte 06h triggers software reset to power-on values.
// - Software reset aborts conversion and releases both alarm outputs.
// - Any other second byte after general call does nothing.
// - Function select 0 gives alert duty, 1 gives second thermal alarm.
// - Alert released on own address read once cause and status cleared.

module smbus_alert_reset_fault_ctrl (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [`ADDR_W-1:0] dev_addr,
  input wire logic alarm_pin_function_select,
  input wire logic alert_mask,
  input wire logic shutdown_control_bit,
  input wire logic supply_valid,
  input wire logic remote_diode_positive_fault,
  input wire logic conv_done,
  input wire alert_pkg::temp_pair_s conv_data,
  input wire alert_pkg::limit_evt_s limit_hit,
  input wire logic critical_thermal_alarm_pin_cond,
  input wire logic therm2_cond,
  input wire logic status_clear,
  output logic multi_function_alarm_pin_o,
  output logic multi_function_alarm_pin_oe,
  output logic critical_thermal_alarm_pin_o,
  output logic critical_thermal_alarm_pin_oe,
  output logic conv_start,
  output logic conv_abort,
  output logic conv_busy,
  output logic power_down,
  output logic soft_reset,
  output logic own_addr_read,
  output logic [`STAT_W-1:0] status,
  output alert_pkg::temp_pair_s result
);

  alert_pkg::link_state_e state_q;
  alert_pkg::link_state_e ack_next_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic sda_oe_q;
  logic ack_phase_q;
  logic gc_reset_q;
  logic ara_won_q;
  logic addr_read_q;
  logic sw_rst_q;
  logic busy_q;
  logic start_q;
  logic abort_q;
  logic fault_seen_q;
  logic [`STAT_W-1:0] status_q;
  logic alert_q;
  logic high_cause_q;
  logic critical_thermal_alarm_pin_hold_q;
  logic mf_oe_q;
  logic crit_oe_q;
  logic rst_all;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rx_byte;
  logic alert_duty;
  logic evt_high;
  logic evt_low;
  logic evt_open;
  logic cause_clear;

  // Byte compare used by both address and general call checks
  function automatic logic byte_is(input logic [7:0] a, input logic [7:0] b);
    byte_is = (a == b);
  endfunction

  assign rst_all = !resetn || sw_rst_q;
  assign scl_rise = scl_i && !scl_prev_q;
  assign scl_fall = !scl_i && scl_prev_q;
  assign bus_start = scl_i && scl_prev_q && sda_prev_q && !sda_i;
  assign bus_stop = scl_i && scl_prev_q && !sda_prev_q && sda_i;
  assign rx_byte = {rx_q[6:0], sda_i};

  assign alert_duty = !alarm_pin_function_select;

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_i;
      sda_prev_q <= sda_i;
    end
  end

  // The serial engine sees only the power-on reset, so a soft reset issued
  // by a general call never cuts the acknowledge that carried it.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_q <= alert_pkg::ST_IDLE;
      ack_next_q <= alert_pkg::ST_SKIP;
      bit_cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      sda_oe_q <= 1'b0;
      ack_phase_q <= 1'b0;
      gc_reset_q <= 1'b0;
      ara_won_q <= 1'b0;
      addr_read_q <= 1'b0;
    end
    else
    begin
      gc_reset_q <= 1'b0;
      ara_won_q <= 1'b0;
      addr_read_q <= 1'b0;
      if (bus_start)
      begin
        state_q <= alert_pkg::ST_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
        ack_phase_q <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_q <= alert_pkg::ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          alert_pkg::ST_ADDR, alert_pkg::ST_GC:
          begin
            if (scl_rise)
            begin
              rx_q <= rx_byte;
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q == `BIT_LAST)
              begin
                ack_phase_q <= 1'b0;
                if (state_q == alert_pkg::ST_GC)
                begin
                  state_q <= alert_pkg::ST_GC_ACK;
                end
                else if (byte_is(rx_byte, `GC_ADDR_BYTE))
                begin
                  state_q <= alert_pkg::ST_ADDR_ACK;
                  ack_next_q <= alert_pkg::ST_GC;
                end
                else if (byte_is(rx_byte, `ARA_BYTE) && alert_q && alert_duty)
                begin
                  state_q <= alert_pkg::ST_ADDR_ACK;
                  ack_next_q <= alert_pkg::ST_ARA;
                end
                else
                begin
                  addr_read_q <= (rx_byte[7:1] == dev_addr) && rx_byte[0];
                  state_q <= alert_pkg::ST_SKIP;
                end
              end
            end
          end
          alert_pkg::ST_ADDR_ACK, alert_pkg::ST_GC_ACK:
          begin
            if (scl_fall)
            begin
              if (!ack_phase_q)
              begin
                ack_phase_q <= 1'b1;
                sda_oe_q <= 1'b1;
              end
              else
              begin
                ack_phase_q <= 1'b0;
                bit_cnt_q <= 4'h0;
                sda_oe_q <= 1'b0;
                if (state_q == alert_pkg::ST_GC_ACK)
                begin
                  gc_reset_q <= byte_is(rx_q, `GC_RESET_BYTE);
                  state_q <= alert_pkg::ST_SKIP;
                end
                else if (ack_next_q == alert_pkg::ST_ARA)
                begin
                  tx_q <= {dev_addr[5:0], high_cause_q, 1'b0};
                  sda_oe_q <= !dev_addr[6];
                  state_q <= alert_pkg::ST_ARA;
                end
                else
                begin
                  state_q <= ack_next_q;
                end
              end
            end
          end
          alert_pkg::ST_ARA:
          begin
            // Open drain: a high bit is sent by letting go of the line
            if (scl_rise)
            begin
              if (!sda_oe_q && !sda_i)
              begin
                state_q <= alert_pkg::ST_SKIP;
              end
              else
              begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
            else if (scl_fall)
            begin
              if (bit_cnt_q == `BIT_DONE)
              begin
                sda_oe_q <= 1'b0;
                state_q <= alert_pkg::ST_ARA_ACK;
              end
              else
              begin
                sda_oe_q <= !tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
              end
            end
          end
          alert_pkg::ST_ARA_ACK:
          begin
            if (scl_rise)
            begin
              ara_won_q <= 1'b1;
              state_q <= alert_pkg::ST_SKIP;
            end
          end
          alert_pkg::ST_IDLE, alert_pkg::ST_SKIP:
          begin
            sda_oe_q <= 1'b0;
          end
          default:
          begin
            state_q <= alert_pkg::ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      sw_rst_q <= 1'b0;
    end
    else
    begin
      sw_rst_q <= gc_reset_q;
    end
  end

  // Conversion sequencer; the analog side runs one conversion per start
  always_ff @(posedge ref_clk)
  begin
    if (rst_all)
    begin
      busy_q <= 1'b0;
      start_q <= 1'b0;
      abort_q <= sw_rst_q && busy_q;
    end
    else if (shutdown_control_bit)
    begin
      busy_q <= 1'b0;
      start_q <= 1'b0;
      abort_q <= busy_q;
    end
    else if (!supply_valid)
    begin
      busy_q <= 1'b0;
      start_q <= 1'b0;
      abort_q <= busy_q;
    end
    else
    begin
      abort_q <= 1'b0;
      start_q <= 1'b0;
      if (busy_q && conv_done)
      begin
        busy_q <= 1'b0;
      end
      else if (!busy_q && !start_q)
      begin
        busy_q <= 1'b1;
        start_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst_all || start_q)
    begin
      fault_seen_q <= 1'b0;
    end
    else if (busy_q && remote_diode_positive_fault)
    begin
      fault_seen_q <= 1'b1;
    end
  end

  assign evt_open = busy_q && conv_done && (fault_seen_q || remote_diode_positive_fault);
  assign evt_high = busy_q && conv_done && limit_hit.high;
  assign evt_low = busy_q && conv_done && limit_hit.low;

  result_hold u_result (
    .ref_clk(ref_clk),
    .clear(rst_all),
    .we_local(busy_q && conv_done && supply_valid && !shutdown_control_bit),
    .we_remote(busy_q && conv_done && supply_valid && !shutdown_control_bit && !evt_open),
    .wdata(conv_data),
    .rdata(result)
  );

  always_ff @(posedge ref_clk)
  begin
    if (rst_all)
    begin
      status_q <= `STAT_RESET;
    end
    else
    begin
      for (int i = 0; i < `STAT_W; i++)
      begin
        if (status_clear)
        begin
          status_q[i] <= 1'b0;
        end
      end
      if (evt_open)
      begin
        status_q[`STAT_OPEN_BIT] <= 1'b1;
      end
      if (evt_high)
      begin
        status_q[`STAT_HIGH_BIT] <= 1'b1;
      end
      if (evt_low)
      begin
        status_q[`STAT_LOW_BIT] <= 1'b1;
      end
    end
  end

  assign cause_clear = !limit_hit.high && !limit_hit.low && !remote_diode_positive_fault
    && (status_q == `STAT_RESET);

  // Alert latch; a fresh unmasked event wins over an alert response or own-address-read release in the same cycle, a soft reset wins over it
  always_ff @(posedge ref_clk)
  begin
    if (rst_all)
    begin
      alert_q <= 1'b0;
      high_cause_q <= 1'b0;
    end
    else if ((evt_open || evt_high || evt_low) && !alert_mask)
    begin
      alert_q <= 1'b1;
      high_cause_q <= evt_high;
    end
    else if (ara_won_q)
    begin
      alert_q <= 1'b0;
    end
    else if (addr_read_q && cause_clear)
    begin
      alert_q <= 1'b0;
    end
  end

  // thermal alarms held off until next result
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      critical_thermal_alarm_pin_hold_q <= 1'b0;
    end
    else if (sw_rst_q)
    begin
      critical_thermal_alarm_pin_hold_q <= 1'b1;
    end
    else if (busy_q && conv_done)
    begin
      critical_thermal_alarm_pin_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst_all)
    begin
      mf_oe_q <= 1'b0;
      crit_oe_q <= 1'b0;
    end
    else
    begin
      mf_oe_q <= alert_duty ? alert_q : (therm2_cond && !critical_thermal_alarm_pin_hold_q);
      crit_oe_q <= critical_thermal_alarm_pin_cond && !critical_thermal_alarm_pin_hold_q;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign multi_function_alarm_pin_o = 1'b0;
  assign multi_function_alarm_pin_oe = mf_oe_q;
  assign critical_thermal_alarm_pin_o = 1'b0;
  assign critical_thermal_alarm_pin_oe = crit_oe_q;
  assign conv_start = start_q;
  assign conv_abort = abort_q;
  assign conv_busy = busy_q;
  assign power_down = shutdown_control_bit;
  assign soft_reset = sw_rst_q;
  assign own_addr_read = addr_read_q;
  assign status = status_q;

endmodule

// ==== verif/smbus_host_model.sv ====
`timescale 1ns/1ps

module smbus_host_model (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Half period in clocks, long enough for the two-sample start and stop filter
  localparam int H = 6;

  initial
  begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Data moves two clocks after the fall so it never reads as a start or stop
  task automatic bit_io(input logic b, input logic rv, output logic r);
    sda_low <= !(b && rv);
    wt(H);
    scl <= 1'h1;
    wt(H);
    r = sda;
    scl <= 1'h0;
    wt(2);
  endtask

  task automatic start();
    sda_low <= 1'h1;
    wt(H);
    scl <= 1'h0;
    wt(2);
  endtask

  task automatic stop();
    sda_low <= 1'h1;
    wt(H);
    scl <= 1'h1;
    wt(H);
    sda_low <= 1'h0;
    wt(H);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], 1'h1, r);
    bit_io(1'h1, 1'h1, r);
    ack = !r;
  endtask

  // A rival responder shares the wire; 8'hff keeps it silent
  task automatic rd_byte(input logic [7:0] rv, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'h1, rv[i], d[i]);
    bit_io(1'h1, 1'h1, r);
  endtask
endmodule

// ==== verif/smbus_alert_reset_fault_ctrl_sva.sv ====
`timescale 1ns/1ps
`include "alert_defines.svh"

module alert_ctrl_sva (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic alarm_pin_function_select,
  input wire logic alert_mask,
  input wire logic shutdown_control_bit,
  input wire logic supply_valid,
  input wire logic remote_diode_positive_fault,
  input wire logic conv_done,
  input wire logic multi_function_alarm_pin_oe,
  input wire logic critical_thermal_alarm_pin_oe,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic conv_busy,
  input wire logic power_down,
  input wire logic soft_reset,
  input wire logic [`STAT_W-1:0] status,
  input wire alert_pkg::temp_pair_s result
);
  wire run_ok = !shutdown_control_bit && supply_valid;
  wire done_ok = conv_busy && conv_done && run_ok;
  wire done_bad = done_ok && remote_diode_positive_fault;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  a_open_drain: assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data line moved while clock high");
  a_shutdown_abort: assert property (conv_busy && !conv_done && $rose(shutdown_control_bit)
    |=> conv_abort && !conv_busy) else $error("shutdown did not abort");
  a_no_start_off: assert property (!run_ok |=> !conv_start)
    else $error("conversion started while stopped");
  a_power_down: assert property (power_down == shutdown_control_bit)
    else $error("power down mismatch");
  a_back_to_back: assert property (done_ok ##1 run_ok |=> conv_start)
    else $error("next conversion late");
  a_remote_kept: assert property (done_bad |=> $stable(result.remote_t))
    else $error("faulty remote result taken");
  a_open_flag: assert property (done_bad |=> status[`STAT_OPEN_BIT])
    else $error("open flag not set");
  a_fault_alert: assert property (done_bad && !alert_mask && !alarm_pin_function_select
    |-> ##[1:3] multi_function_alarm_pin_oe) else $error("fault did not raise alert");
  a_reset_release: assert property (soft_reset |-> ##[0:2] (status == 8'h00
    && result == 24'h000000 && !multi_function_alarm_pin_oe && !critical_thermal_alarm_pin_oe))
    else $error("soft reset left state");
  a_resume: assert property (soft_reset && run_ok |-> ##[1:8] conv_start)
    else $error("no conversion after soft reset");

  cover property (soft_reset);
  cover property (conv_abort);
  cover property ($fell(multi_function_alarm_pin_oe));
endmodule

bind smbus_alert_reset_fault_ctrl alert_ctrl_sva u_sva (
  .ref_clk, .resetn, .scl_i, .sda_o, .sda_oe, .alarm_pin_function_select, .alert_mask,
  .shutdown_control_bit, .supply_valid, .remote_diode_positive_fault, .conv_done,
  .multi_function_alarm_pin_oe, .critical_thermal_alarm_pin_oe, .conv_start, .conv_abort,
  .conv_busy, .power_down, .soft_reset, .status, .result
);

// ==== verif/smbus_alert_reset_fault_ctrl_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module smbus_alert_reset_fault_ctrl_tb;
  typedef struct packed {
    logic [23:0] d;
    logic [1:0] hit;
    logic f;
    logic [11:0] er;
    logic [7:0] es;
    logic ea;
  } row_s;
  logic ref_clk, resetn, sel, shut, supply_valid, fault, conv_done, therm2_cond, status_clear;
  logic scl, host_low, sda_o, sda_oe, alert_oe, crit_oe, conv_start, conv_abort, conv_busy;
  logic power_down, soft_reset, own_rd, ack;
  logic critical_thermal_alarm_pin_cond, mask;
  logic [7:0] status, rd;
  alert_pkg::temp_pair_s conv_data, result;
  alert_pkg::limit_evt_s limit_hit;
  int err_count, n_compared, n_start, n_abort, n_sr, n_own, s0, s1, s2;
  row_s rows [6];
  // Pulled-up wire: released means high
  wire sda = !(sda_oe && !sda_o) && !host_low;

  smbus_alert_reset_fault_ctrl u_dut (
    .ref_clk, .resetn, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .dev_addr(7'h4c),
    .alarm_pin_function_select(sel), .alert_mask(mask), .shutdown_control_bit(shut),
    .supply_valid, .remote_diode_positive_fault(fault), .conv_done, .conv_data, .limit_hit,
    .critical_thermal_alarm_pin_cond, .therm2_cond, .status_clear, .multi_function_alarm_pin_o(),
    .multi_function_alarm_pin_oe(alert_oe), .critical_thermal_alarm_pin_o(),
    .critical_thermal_alarm_pin_oe(crit_oe), .conv_start, .conv_abort, .conv_busy,
    .power_down, .soft_reset, .own_addr_read(own_rd), .status, .result
  );
  smbus_host_model u_host (.ref_clk, .sda, .scl, .sda_low(host_low));

  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    n_start += (conv_start === 1'h1);
    n_abort += (conv_abort === 1'h1);
    n_sr += (soft_reset === 1'h1);
    n_own += (own_rd === 1'h1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic clr();
    status_clear <= 1'h1;
    tick(1);
    status_clear <= 1'h0;
    tick(2);
  endtask

  // Mode 0 address only, 1 write b, 2 read with rival pattern b
  task automatic bus(input logic [7:0] a, input int mode, input logic [7:0] b);
    logic k;
    u_host.start();
    u_host.wr_byte(a, ack);
    if (mode == 1)
      u_host.wr_byte(b, k);
    if (mode == 2)
      u_host.rd_byte(b, rd);
    u_host.stop();
  endtask

  task automatic run_row(input int i);
    int n;
    n = 0;
    while (conv_busy !== 1'h1 && n < 40)
    begin
      tick(1);
      n++;
    end
    conv_data <= rows[i].d;
    limit_hit <= rows[i].hit;
    fault <= rows[i].f;
    conv_done <= 1'h1;
    tick(1);
    conv_done <= 1'h0;
    limit_hit <= 2'h0;
    fault <= 1'h0;
    tick(3);
    `CHK("remote", rows[i].er, result.remote_t)
    `CHK("local", rows[i].d[23:12], result.local_t)
    `CHK("status", rows[i].es, status)
    `CHK("alert", rows[i].ea, alert_oe)
  endtask

  task automatic results();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    tick(30000);
    err_count++;
    results();
  end

  initial
  begin
    resetn = 1'h0;
    sel = 1'h0;
    shut = 1'h0;
    supply_valid = 1'h1;
    fault = 1'h0;
    conv_done = 1'h0;
    therm2_cond = 1'h0;
    critical_thermal_alarm_pin_cond = 1'h0;
    mask = 1'h0;
    status_clear = 1'h0;
    conv_data = 24'h0;
    limit_hit = 2'h0;
    rows[0] = '{24'h123456, 2'h0, 1'h0, 12'h456, 8'h00, 1'h0};
    rows[1] = '{24'h124460, 2'h2, 1'h0, 12'h460, 8'h10, 1'h1};
    rows[2] = '{24'h125461, 2'h1, 1'h0, 12'h461, 8'h18, 1'h1};
    rows[3] = '{24'h1267ff, 2'h0, 1'h1, 12'h461, 8'h04, 1'h1};
    rows[4] = '{24'h127800, 2'h0, 1'h1, 12'h000, 8'h04, 1'h1};
    rows[5] = '{24'h128800, 2'h2, 1'h0, 12'h800, 8'h10, 1'h0};
    tick(3);
    resetn <= 1'h1;
    `CHK("result", 24'h0, result)
    for (int i = 0; i < 2; i++)
      run_row(i);
    sel <= 1'h1;
    tick(2);
    bus(8'h19, 2, 8'hff);
    `CHK("ara_ack", 1'h0, ack)
    therm2_cond <= 1'h1;
    tick(4);
    `CHK("therm2", 1'h1, alert_oe)
    therm2_cond <= 1'h0;
    tick(4);
    `CHK("therm2", 1'h0, alert_oe)
    sel <= 1'h0;
    tick(2);
    bus(8'h19, 2, 8'hff);
    `CHK("ara_ack", 1'h1, ack)
    `CHK("ara_addr", 8'h99, rd)
    `CHK("alert", 1'h0, alert_oe)
    run_row(2);
    bus(8'h19, 2, 8'h87);
    `CHK("ara_lost", 8'h87, rd)
    `CHK("alert", 1'h1, alert_oe)
    bus(8'h19, 2, 8'hff);
    `CHK("ara_addr", 8'h98, rd)
    `CHK("alert", 1'h0, alert_oe)
    clr();
    run_row(3);
    bus(8'h00, 1, 8'h05);
    `CHK("gc_ack", 1'h1, ack)
    `CHK("status", 8'h04, status)
    `CHK("result", 24'h126461, result)
    critical_thermal_alarm_pin_cond <= 1'h1;
    tick(3);
    `CHK("crit", 1'h1, crit_oe)
    s0 = n_sr;
    s1 = n_start;
    s2 = n_abort;
    bus(8'h00, 1, 8'h06);
    `CHK("soft", 1, n_sr - s0)
    `CHK("abort", 1'h1, n_abort > s2)
    `CHK("status", 8'h00, status)
    `CHK("result", 24'h0, result)
    `CHK("alarms", 2'h0, {alert_oe, crit_oe})
    `CHK("restart", 1'h1, n_start > s1)
    critical_thermal_alarm_pin_cond <= 1'h0;
    run_row(4);
    clr();
    s0 = n_own;
    bus({7'h4c, 1'h1}, 0, 8'h00);
    `CHK("own_read", 1'h1, n_own > s0)
    `CHK("alert", 1'h0, alert_oe)
    tick(4);
    s0 = n_abort;
    shut <= 1'h1;
    tick(3);
    `CHK("abort", 1'h1, n_abort > s0)
    `CHK("busy", 1'h0, conv_busy)
    `CHK("power_down", 1'h1, power_down)
    s1 = n_start;
    bus(8'h00, 1, 8'h05);
    `CHK("gc_ack", 1'h1, ack)
    `CHK("starts", s1, n_start)
    shut <= 1'h0;
    tick(4);
    `CHK("starts", 1'h1, n_start > s1)
    supply_valid <= 1'h0;
    tick(3);
    s1 = n_start;
    tick(20);
    `CHK("busy", 1'h0, conv_busy)
    `CHK("starts", s1, n_start)
    `CHK("result", 24'h127000, result)
    supply_valid <= 1'h1;
    mask <= 1'h1;
    run_row(5);
    results();
  end
endmodule
